/* File: shared/ebarb_cfg.svh */
// Purpose: offsets, field positions, reset values and counts for ebarb
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes: definitions only
`ifndef EBARB_CFG_SVH
`define EBARB_CFG_SVH
`define EBARB_OFF_CTRL 4'h0
`define EBARB_OFF_WCR 4'h4
`define EBARB_OFF_STAT 4'h8
`define EBARB_CTRL_PSM 0
`define EBARB_CTRL_RASD 1
`define EBARB_CTRL_RST 32'h0000_0000
`define EBARB_WCR_RST 32'h0000_0000
`define EBARB_WCR_DMA_LSB 21
`define EBARB_IW_W 3
`define EBARB_AREAS 3'h7
`define EBARB_PSM_AREA 3'h2
`define EBARB_GAP_MAX 4'hf
`define EBARB_STRAP_AGE 2'h2
`define EBARB_RESP_OK 2'h0
`define EBARB_RESP_ERR 2'h2
`endif

/* File: shared/ebarb_pkg.sv */
// Purpose: types shared by the arbitration block
// Assumes: nothing
// Notes: register state travels as one packed struct
package ebarb_pkg;
    typedef enum logic [3:0] {
        ST_FLOAT, ST_OWN, ST_IWAIT, ST_CYCLE, ST_RIW, ST_PRECH,
        ST_NEG, ST_GRANT, ST_REL, ST_REACQ, ST_SREQ
    } ebarb_state_e;
    typedef enum logic [1:0] {OWN_NONE, OWN_CPU, OWN_DMA, OWN_REF} ebarb_owner_e;
    // one bus access request from an internal master
    typedef struct packed {
        logic valid;
        logic [2:0] area;
        logic write;
        logic lock;
        logic single_io2mem;
    } ebarb_req_s;
    typedef struct packed {
        ebarb_state_e st;
        ebarb_owner_e owner;
        ebarb_req_s cur;
        logic prev_valid;
        logic prev_write;
        logic [2:0] prev_area;
        logic [3:0] gap;
        logic [3:0] cnt;
        logic lock;
        logic acq;
        logic refresh_after;
        logic slave_mode;
        logic strap_done;
        logic [1:0] strap_cnt;
        logic psm;
        logic ras_down;
        logic [31:0] wcr;
        logic grant_n;
        logic sreq_n;
        logic ctrl_oe_n;
        logic bus_oe_n;
        logic ctrl_neg;
        logic start;
        logic pre_cmd;
        logic pre_all;
        logic aw_got;
        logic [3:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awrdy;
        logic wrdy;
        logic arrdy;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [1:0] bus_request_n_sync;
        logic [1:0] ack_sync;
        logic [1:0] mode_sync;
    } ebarb_state_s;
endpackage

/* File: src/ebarb_top.sv */
// Purpose: external bus arbitration and inter-cycle idle wait insertion
// Assumes: memory side reports cycle_done, bank_open and precharge_done
// Notes: dma acks and sdram cke live elsewhere and are never floated here
`timescale 1ns/1ps
`include "ebarb_cfg.svh"
module ebarb_top (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire ebarb_pkg::ebarb_req_s cpu_req,
    input wire ebarb_pkg::ebarb_req_s dma_req,
    input wire logic refresh_req,
    input wire logic cycle_done,
    input wire logic bank_open,
    input wire logic precharge_done,
    input wire logic bus_request_n,
    input wire logic slave_ack_n,
    input wire logic mode_slave,
    output logic bus_grant_n,
    output logic slave_req_n,
    output logic ctrl_oe_n,
    output logic bus_oe_n,
    output logic ctrl_negate,
    output logic cycle_start,
    output ebarb_pkg::ebarb_owner_e cycle_owner,
    output ebarb_pkg::ebarb_req_s cycle_req,
    output logic precharge_cmd,
    output logic precharge_all_command
);
    ebarb_pkg::ebarb_state_s r, n;
    ebarb_pkg::ebarb_req_s sel;
    ebarb_pkg::ebarb_owner_e sel_own;
    logic bus_request_n_on, ext_go, ref_go, dma_ok, cpu_ok, acc_go;
    logic coll, slv_sel, slv_cur, pre_need;
    logic [3:0] iw_sel, need, rel_need;
    logic [31:0] ctrl_wr;

    // ***************************************
    // helpers
    // ***************************************
    function automatic logic [2:0] area_iw(input logic [31:0] w, input logic [2:0] a);
        if (a == `EBARB_AREAS) begin
            return 3'h0;
        end
        return w[32'(a) * `EBARB_IW_W +: `EBARB_IW_W];
    endfunction

    function automatic logic [3:0] sat_sub(input logic [3:0] a, input logic [3:0] b);
        return (a > b) ? 4'(a - b) : 4'h0;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] m;
        m = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                m[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return m;
    endfunction

    // ***************************************
    // arbitration decision terms
    // ***************************************
    // only the second synchroniser stage is ever looked at
    assign bus_request_n_on = !r.bus_request_n_sync[1];
    // external requester only in plain master mode, never inside a lock
    assign ext_go = r.strap_done && !r.slave_mode && !r.psm && bus_request_n_on && !r.lock;
    assign ref_go = refresh_req && !r.lock && !r.slave_mode;
    assign dma_ok = dma_req.valid && (!r.lock || r.owner == ebarb_pkg::OWN_DMA);
    assign cpu_ok = cpu_req.valid && (!r.lock || r.owner == ebarb_pkg::OWN_CPU);
    // fixed order: external, refresh, dma, cpu
    assign acc_go = !ext_go && !ref_go && (dma_ok || cpu_ok);
    assign sel = dma_ok ? dma_req : cpu_req;
    assign sel_own = dma_ok ? ebarb_pkg::OWN_DMA : ebarb_pkg::OWN_CPU;
    // write-write and same-area read-read never turn the data bus round
    assign coll = r.prev_valid && !(r.prev_write && sel.write)
        && !(!r.prev_write && !sel.write && sel.area == r.prev_area);
    // single io-to-memory dma takes the dma field, dual dma the area field
    assign iw_sel = sel.single_io2mem ? r.wcr[`EBARB_WCR_DMA_LSB +: 4]
        : {1'b0, area_iw(r.wcr, r.prev_area)};
    assign need = coll ? sat_sub(iw_sel, r.gap) : 4'h0;
    assign rel_need = (r.prev_valid && !r.prev_write)
        ? sat_sub({1'b0, area_iw(r.wcr, r.prev_area)}, r.gap) : 4'h0;
    assign slv_sel = r.slave_mode || (r.psm && sel.area == `EBARB_PSM_AREA);
    assign slv_cur = r.slave_mode || (r.psm && r.cur.area == `EBARB_PSM_AREA);
    assign pre_need = r.ras_down || bank_open;

    // ***************************************
    // next state
    // ***************************************
    always_comb begin
        n = r;
        ctrl_wr = 32'h0000_0000;
        n.start = 1'b0;
        n.pre_cmd = 1'b0;
        n.bus_request_n_sync = {r.bus_request_n_sync[0], bus_request_n};
        n.ack_sync = {r.ack_sync[0], slave_ack_n};
        n.mode_sync = {r.mode_sync[0], mode_slave};
        unique case (r.st)
            ebarb_pkg::ST_FLOAT: begin
                if (!r.strap_done) begin
                    // strap caught only after it has crossed both stages
                    n.strap_cnt = 2'(r.strap_cnt + 2'h1);
                    if (r.strap_cnt == `EBARB_STRAP_AGE) begin
                        n.strap_done = 1'b1;
                        n.slave_mode = r.mode_sync[1];
                        if (!r.mode_sync[1]) begin
                            n.ctrl_oe_n = 1'b0;
                            n.st = ebarb_pkg::ST_REACQ;
                        end
                    end
                end else if (cpu_req.valid || dma_req.valid) begin
                    n.sreq_n = 1'b0;
                    n.st = ebarb_pkg::ST_SREQ;
                end
            end
            ebarb_pkg::ST_SREQ: begin
                if (!r.ack_sync[1]) begin
                    n.acq = 1'b1;
                    if (r.slave_mode) begin
                        n.ctrl_oe_n = 1'b0;
                        n.st = ebarb_pkg::ST_REACQ;
                    end else begin
                        n.st = ebarb_pkg::ST_OWN;
                    end
                end
            end
            ebarb_pkg::ST_OWN: begin
                if (r.gap != `EBARB_GAP_MAX) begin
                    n.gap = 4'(r.gap + 4'h1);
                end
                if (ext_go) begin
                    n.cnt = rel_need;
                    n.st = (rel_need != 4'h0) ? ebarb_pkg::ST_RIW
                        : pre_need ? ebarb_pkg::ST_PRECH : ebarb_pkg::ST_NEG;
                end else if (ref_go) begin
                    n.owner = ebarb_pkg::OWN_REF;
                    n.lock = 1'b0;
                    n.refresh_after = r.ras_down;
                    n.st = r.ras_down ? ebarb_pkg::ST_PRECH : ebarb_pkg::ST_CYCLE;
                end else if (acc_go && slv_sel && !r.acq) begin
                    n.sreq_n = 1'b0;
                    n.st = ebarb_pkg::ST_SREQ;
                end else if (acc_go) begin
                    n.cur = sel;
                    n.owner = sel_own;
                    n.lock = sel.lock;
                    n.cnt = need;
                    n.st = (need != 4'h0) ? ebarb_pkg::ST_IWAIT : ebarb_pkg::ST_CYCLE;
                end else if (r.acq && !r.lock) begin
                    n.cnt = rel_need;
                    n.st = (rel_need != 4'h0) ? ebarb_pkg::ST_RIW
                        : pre_need ? ebarb_pkg::ST_PRECH : ebarb_pkg::ST_NEG;
                end
            end
            ebarb_pkg::ST_IWAIT: begin
                n.cnt = 4'(r.cnt - 4'h1);
                if (r.cnt == 4'h1) begin
                    n.st = ebarb_pkg::ST_CYCLE;
                end
            end
            ebarb_pkg::ST_CYCLE: begin
                if (cycle_done) begin
                    n.gap = 4'h0;
                    if (r.owner != ebarb_pkg::OWN_REF) begin
                        n.prev_valid = 1'b1;
                        n.prev_write = r.cur.write;
                        n.prev_area = r.cur.area;
                    end
                    n.st = ebarb_pkg::ST_OWN;
                    // slave-type access gives the bus back unless locked
                    if (!r.lock && slv_cur && r.owner != ebarb_pkg::OWN_REF) begin
                        n.cnt = rel_need;
                        n.st = (rel_need != 4'h0) ? ebarb_pkg::ST_RIW
                            : pre_need ? ebarb_pkg::ST_PRECH : ebarb_pkg::ST_NEG;
                    end
                end
            end
            ebarb_pkg::ST_RIW: begin
                n.cnt = 4'(r.cnt - 4'h1);
                if (r.cnt == 4'h1) begin
                    n.st = pre_need ? ebarb_pkg::ST_PRECH : ebarb_pkg::ST_NEG;
                end
            end
            ebarb_pkg::ST_PRECH: begin
                // release waits for precharge to complete
                if (precharge_done) begin
                    n.refresh_after = 1'b0;
                    n.st = r.refresh_after ? ebarb_pkg::ST_CYCLE : ebarb_pkg::ST_NEG;
                end
            end
            ebarb_pkg::ST_NEG: begin
                if (r.slave_mode || r.psm) begin
                    n.sreq_n = 1'b1;
                    n.acq = 1'b0;
                end else begin
                    n.grant_n = 1'b0;
                end
                n.st = ebarb_pkg::ST_GRANT;
            end
            ebarb_pkg::ST_GRANT: begin
                if (r.psm) begin
                    n.st = ebarb_pkg::ST_OWN;
                end else begin
                    n.ctrl_oe_n = 1'b1;
                    n.bus_oe_n = 1'b1;
                    n.st = r.slave_mode ? ebarb_pkg::ST_FLOAT : ebarb_pkg::ST_REL;
                end
            end
            ebarb_pkg::ST_REL: begin
                // refresh deferred; ask the requester to hand the bus back
                if (refresh_req) begin
                    n.grant_n = 1'b1;
                end
                if (!bus_request_n_on) begin
                    n.grant_n = 1'b1;
                    n.ctrl_oe_n = 1'b0;
                    n.st = ebarb_pkg::ST_REACQ;
                end
            end
            ebarb_pkg::ST_REACQ: begin
                n.bus_oe_n = 1'b0;
                n.st = ebarb_pkg::ST_OWN;
            end
            default: begin
                n.st = ebarb_pkg::ST_FLOAT;
            end
        endcase
        // entry actions shared by several paths
        if (n.st == ebarb_pkg::ST_PRECH && r.st != ebarb_pkg::ST_PRECH) begin
            n.pre_cmd = 1'b1;
            n.pre_all = r.ras_down;
        end
        if (n.st == ebarb_pkg::ST_NEG) begin
            n.ctrl_neg = 1'b1;
        end
        if (n.st == ebarb_pkg::ST_CYCLE && r.st != ebarb_pkg::ST_CYCLE) begin
            n.start = 1'b1;
            n.ctrl_neg = 1'b0;
        end

        // register bus: finish answers first, then accept new items
        if (r.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (r.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_awvalid && r.awrdy) begin
            n.aw_got = 1'b1;
            n.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && r.wrdy) begin
            n.w_got = 1'b1;
            n.w_data = s_axi_wdata;
            n.w_strb = s_axi_wstrb;
        end
        if (n.aw_got && n.w_got && !n.bvalid) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = `EBARB_RESP_OK;
            unique case (n.aw_addr)
                `EBARB_OFF_CTRL: begin
                    // a function result cannot be indexed, so merge into a word first
                    ctrl_wr = merge({30'h0, r.ras_down, r.psm}, n.w_data, n.w_strb);
                    n.psm = ctrl_wr[`EBARB_CTRL_PSM];
                    n.ras_down = ctrl_wr[`EBARB_CTRL_RASD];
                end
                `EBARB_OFF_WCR: n.wcr = merge(r.wcr, n.w_data, n.w_strb);
                default: n.bresp = `EBARB_RESP_ERR;
            endcase
        end
        if (s_axi_arvalid && r.arrdy) begin
            n.rvalid = 1'b1;
            n.rresp = `EBARB_RESP_OK;
            unique case (s_axi_araddr)
                `EBARB_OFF_CTRL: n.rdata = {30'h0, r.ras_down, r.psm};
                `EBARB_OFF_WCR: n.rdata = r.wcr;
                `EBARB_OFF_STAT: n.rdata = {18'h0, r.acq, r.slave_mode, r.prev_write,
                    r.prev_area, refresh_req, !r.grant_n, r.owner, r.st};
                default: begin
                    n.rdata = 32'h0000_0000;
                    n.rresp = `EBARB_RESP_ERR;
                end
            endcase
        end
        n.awrdy = !n.aw_got && !n.bvalid;
        n.wrdy = !n.w_got && !n.bvalid;
        n.arrdy = !n.rvalid;
    end

    // ***************************************
    // state register
    // ***************************************
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            r <= '0;
            r.grant_n <= 1'b1;
            r.sreq_n <= 1'b1;
            r.ctrl_oe_n <= 1'b1;
            r.bus_oe_n <= 1'b1;
            r.ctrl_neg <= 1'b1;
            r.wcr <= `EBARB_WCR_RST;
            r.bus_request_n_sync <= 2'h3;
            r.ack_sync <= 2'h3;
        end else begin
            r <= n;
        end
    end

    // outputs straight from the state register
    assign s_axi_awready = r.awrdy;
    assign s_axi_wready = r.wrdy;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = r.arrdy;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;
    assign bus_grant_n = r.grant_n;
    assign slave_req_n = r.sreq_n;
    assign ctrl_oe_n = r.ctrl_oe_n;
    assign bus_oe_n = r.bus_oe_n;
    assign ctrl_negate = r.ctrl_neg;
    assign cycle_start = r.start;
    assign cycle_owner = r.owner;
    assign cycle_req = r.cur;
    assign precharge_cmd = r.pre_cmd;
    assign precharge_all_command = r.pre_all;

    // ***************************************
    // checks
    // ***************************************
    property p_float_after_grant;
        @(posedge mclk) disable iff (!rstn)
        $fell(r.grant_n) |=> r.bus_oe_n && r.ctrl_oe_n;
    endproperty
    a_float_after_grant: assert property (p_float_after_grant)
        else $error("bus not floated one edge after grant");

    property p_reacquire;
        @(posedge mclk) disable iff (!rstn)
        (r.st == ebarb_pkg::ST_REL && r.bus_request_n_sync[1])
            |=> r.grant_n && !r.ctrl_oe_n && r.bus_oe_n ##1 !r.bus_oe_n;
    endproperty
    a_reacquire: assert property (p_reacquire)
        else $error("re-acquire order wrong");

    property p_refresh_withdraw;
        @(posedge mclk) disable iff (!rstn)
        (r.st == ebarb_pkg::ST_REL && refresh_req) |=> r.grant_n;
    endproperty
    a_refresh_withdraw: assert property (p_refresh_withdraw)
        else $error("grant kept during pending refresh");

    property p_negated_first;
        @(posedge mclk) disable iff (!rstn)
        $fell(r.grant_n) |-> r.ctrl_neg && $past(r.ctrl_neg) && !r.ctrl_oe_n;
    endproperty
    a_negated_first: assert property (p_negated_first)
        else $error("controls not negated before release");

    property p_lock_held;
        @(posedge mclk) disable iff (!rstn)
        (r.st == ebarb_pkg::ST_OWN && r.lock)
            |=> r.st inside {ebarb_pkg::ST_OWN, ebarb_pkg::ST_IWAIT, ebarb_pkg::ST_CYCLE};
    endproperty
    a_lock_held: assert property (p_lock_held)
        else $error("bus released or refreshed inside a locked sequence");

    property p_no_ww_idle;
        @(posedge mclk) disable iff (!rstn)
        (r.st == ebarb_pkg::ST_OWN && acc_go && !slv_sel && r.prev_write && sel.write)
            |=> r.st == ebarb_pkg::ST_CYCLE && r.start;
    endproperty
    a_no_ww_idle: assert property (p_no_ww_idle)
        else $error("idle inserted between writes");

    property p_idle_end;
        @(posedge mclk) disable iff (!rstn)
        (r.st == ebarb_pkg::ST_IWAIT && r.cnt == 4'h1) |=> r.start ##1 !r.start;
    endproperty
    a_idle_end: assert property (p_idle_end)
        else $error("access not started after idle count");

    property p_release_after_idle;
        @(posedge mclk) disable iff (!rstn)
        (r.st == ebarb_pkg::ST_RIW) |-> r.grant_n && r.sreq_n == $past(r.sreq_n);
    endproperty
    a_release_after_idle: assert property (p_release_after_idle)
        else $error("bus given away during idle waits");

    property p_precharge_all_command_refresh;
        @(posedge mclk) disable iff (!rstn)
        (r.st == ebarb_pkg::ST_OWN && !ext_go && ref_go && r.ras_down)
            |=> r.pre_cmd && r.pre_all && !r.start;
    endproperty
    a_precharge_all_command_refresh: assert property (p_precharge_all_command_refresh)
        else $error("no precharge-all before refresh");

    property p_prech_wait;
        @(posedge mclk) disable iff (!rstn)
        (r.st == ebarb_pkg::ST_PRECH && !precharge_done) |=> r.st == ebarb_pkg::ST_PRECH;
    endproperty
    a_prech_wait: assert property (p_prech_wait)
        else $error("left precharge before it completed");

    property p_psm_driven;
        @(posedge mclk) disable iff (!rstn)
        (r.psm && r.st == ebarb_pkg::ST_GRANT) |=> !r.bus_oe_n && !r.ctrl_oe_n;
    endproperty
    a_psm_driven: assert property (p_psm_driven)
        else $error("partial-sharing bus floated");
endmodule

/* File: verif/ebarb_ext_master.sv */
// Purpose: external requester that borrows the bus from the arbiter
// Assumes: grant and request are active low, sampled on mclk
// Notes: yields at once when the grant is withdrawn
`timescale 1ns/1ps
module ebarb_ext_master (
    input wire logic mclk,
    input wire logic want,
    input wire logic bus_grant_n,
    output logic bus_request_n
);
    logic had_r = 1'b0;
    logic [1:0] quiet_r = 2'h0;
    // request while wanted; after a yield stay quiet so the arbiter can take the bus back
    always @(posedge mclk) begin
        if (!bus_grant_n) had_r <= 1'b1;
        if ((had_r && bus_grant_n) || !want) begin
            bus_request_n <= 1'b1;
            had_r <= 1'b0;
            quiet_r <= 2'h2;
        end else if (quiet_r != 2'h0) quiet_r <= quiet_r - 2'h1;
        else bus_request_n <= 1'b0;
    end
    initial bus_request_n = 1'b1;
endmodule

/* File: verif/external_bus_arbitration_tb_top.sv */
// Purpose: self-checking bench for the bus arbiter
// Assumes: master mode strap, no open dram bank
// Notes: idle counts are judged against a no-idle baseline latency
`timescale 1ns/1ps
module external_bus_arbitration_tb_top;
    logic mclk = 0, rstn = 0, refresh_req = 0, cycle_done = 0, want = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, bank_open = 0, precharge_done = 0, slave_ack_n = 1, mode_slave = 0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    ebarb_pkg::ebarb_req_s cpu_req = '0, dma_req = '0, cycle_req;
    ebarb_pkg::ebarb_owner_e cycle_owner;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, bus_grant_n;
    logic slave_req_n, ctrl_oe_n, bus_oe_n, ctrl_negate, cycle_start, precharge_cmd;
    logic precharge_all_command, bus_request_n;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int err_total = 0, n_checks = 0, lat = 0, n_pre = 0;
    // rows: dma, single io-to-memory, area, write, expected idles
    logic [9:0] rows [8] = '{10'h010, 10'h030, 10'h025, 10'h020, 10'h005, 10'h013, 10'h349, 10'h232};
    ebarb_top dut (.*);
    ebarb_ext_master u_ext (.*);
    initial forever #2 mclk = ~mclk;
    // memory side ends each cycle one clock after it starts; lat counts clocks since
    always @(posedge mclk) begin
        cycle_done <= cycle_start;
        lat <= cycle_done ? 0 : lat + 1;
        // precharge completes one clock after the command
        precharge_done <= precharge_cmd;
        if (precharge_cmd && precharge_all_command) n_pre <= n_pre + 1;
    end
    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
    endtask
    task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    // bounded wait for the next cycle start pulse
    task automatic wstart;
        int k;
        k = 0;
        do @(posedge mclk); while (cycle_start !== 1'b1 && k++ < 80);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #80000;
        err_total++;
        print_verdict;
    end
    initial begin
        int i, k, base;
        logic [31:0] d;
        logic [1:0] r;
        ebarb_pkg::ebarb_req_s q;
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        chk(bus_grant_n === 1'b1 && bus_oe_n === 1'b1, "reset floats bus");
        repeat (8) @(posedge mclk);
        chk(bus_oe_n === 1'b0, "master holds bus");
        // area 0:3, area 1:5, area 2:2, dma field 9
        axw(4'h4, 32'h0120_00ab, r);
        axr(4'h4, d, r);
        chk(d === 32'h0120_00ab && r === 2'h0, "idle field readback");
        axr(4'hc, d, r);
        chk(r === 2'h2, "unmapped read");
        axw(4'h8, 32'h0000_0001, r);
        chk(r === 2'h2, "status write");
        $display("reset and register test done");
        for (i = 0; i < 8; i++) begin
            q = '{1'b1, rows[i][7:5], rows[i][4], 1'b0, rows[i][8]};
            cpu_req <= rows[i][9] ? 7'h00 : q;
            dma_req <= rows[i][9] ? q : 7'h00;
            wstart;
            chk(cycle_owner === {rows[i][9], !rows[i][9]}, "owner");
            if (i == 1) base = lat;
            if (i > 1) chk(lat === base + rows[i][3:0], "idle count");
        end
        $display("idle table done");
        // all three internal masters at once: refresh, then dma, then cpu
        refresh_req <= 1'b1;
        cpu_req <= '{1'b1, 3'h3, 1'b0, 1'b0, 1'b0};
        dma_req <= '{1'b1, 3'h4, 1'b0, 1'b0, 1'b0};
        for (i = 3; i > 0; i--) begin
            wstart;
            chk(cycle_owner === i[1:0], "priority");
            if (i == 3) refresh_req <= 1'b0;
            else if (i == 2) dma_req <= 7'h00;
            else cpu_req <= 7'h00;
        end
        $display("priority test done");
        want <= 1'b1;
        for (k = 0; k < 60 && bus_grant_n !== 1'b0; k++) @(posedge mclk);
        chk(bus_grant_n === 1'b0, "grant given");
        @(posedge mclk);
        chk(bus_oe_n === 1'b1 && ctrl_oe_n === 1'b1, "bus floated");
        refresh_req <= 1'b1;
        for (k = 0; k < 10 && bus_grant_n !== 1'b0; k++) @(posedge mclk);
        for (k = 0; k < 10 && bus_grant_n !== 1'b1; k++) @(posedge mclk);
        chk(bus_grant_n === 1'b1 && bus_request_n === 1'b0, "grant withdrawn");
        want <= 1'b0;
        wstart;
        chk(cycle_owner === 2'h3 && bus_oe_n === 1'b0, "refresh after return");
        refresh_req <= 1'b0;
        $display("release test done");
        // ras-down mode: refresh must be preceded by precharge-all
        axw(4'h0, 32'h0000_0002, r);
        refresh_req <= 1'b1;
        wstart;
        chk(cycle_owner === 2'h3 && n_pre == 1, "precharge-all before refresh");
        refresh_req <= 1'b0;
        $display("ras-down test done");
        print_verdict;
    end
endmodule
